// >>> include/panel_pad_pkg.sv
// Register map, field layout and reset values for the panel output pad control block.
package panel_pad_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DELAY_W = 5;
  localparam int DRIVE_W = 3;
  localparam int NUM_DELAY = 19;
  localparam int NUM_DRIVE = 21;
  localparam int CODES_PER_REG = 8;
  localparam int NUM_DRIVE_REG = 3;
  localparam int NUM_BIDIR = 3;
  localparam int NUM_STRAP = 2;
  localparam int PHASE_W = 8;
  localparam int PREDIV_W = 16;
  // Delay slots in register order; the panel clock delay sits in output_control_one.
  localparam int DLY_PCLK = 8;
  // Drive code slots: 0..1 polarity flags, 2..7 data groups, 8..17 sync generators.
  localparam int DRV_PWM = 18;
  localparam int DRV_OUTEN = 19;
  localparam int DRV_PCLK = 20;
  localparam logic [ADDR_W-1:0] OFF_DELAY_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DRIVE_BASE = 8'h50;
  localparam logic [ADDR_W-1:0] OFF_BRIGHT0 = 8'h60;
  localparam logic [ADDR_W-1:0] OFF_BRIGHT1 = 8'h64;
  localparam logic [ADDR_W-1:0] OFF_PIN_DIR = 8'h68;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h6C;
  localparam int BR_WIDTH_LSB = 0;
  localparam int BR_SYNC_BIT = 8;
  localparam int BR_INV_BIT = 9;
  localparam int ST_STRAP_LSB = 0;
  localparam int ST_OUT_BIT = 4;
  localparam int ST_PHASE_LSB = 8;
  localparam logic [DRIVE_W-1:0] DRIVE_RESET = 3'h0;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 5'h00;
  localparam logic [PHASE_W-1:0] WIDTH_RESET = 8'h00;
  localparam logic [PREDIV_W-1:0] PREDIV_RESET = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } wr_state_t;
endpackage : panel_pad_pkg

// >>> design/brightness_pwm.sv
// Brightness pulse width modulator with pre-divider, sync to the horizontal gate and polarity inversion.
module brightness_pwm
  import panel_pad_pkg::*;
#(
  parameter int DIV_W = PREDIV_W,
  parameter int CNT_W = PHASE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  input wire logic [DIV_W-1:0] prediv,
  input wire logic [CNT_W-1:0] width,
  input wire logic syncEnable,
  input wire logic invert,
  input wire logic hGate,
  // Result
  output logic pwmOut,
  output logic [CNT_W-1:0] phase
);
  logic [DIV_W-1:0] divCount;
  logic hGateQ;
  logic syncHit;
  logic tick;

  assign syncHit = syncEnable && hGate && !hGateQ;
  // A compare with >= keeps the divider safe when software lowers the value mid-count.
  assign tick = divCount >= prediv;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hGateQ <= 1'b0;
    end else begin
      hGateQ <= hGate;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      divCount <= '0;
    end else if (syncHit || tick) begin
      divCount <= '0;
    end else begin
      divCount <= divCount + DIV_W'(1);
    end
  end

  // The phase wraps naturally after 255, so a period is 256 divided ticks.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase <= '0;
    end else if (syncHit) begin
      phase <= '0;
    end else if (tick) begin
      phase <= phase + CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= (phase < width) ^ invert;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pwm_wrap_a: assert property (tick && !syncHit && phase == '1 |=> phase == '0)
    else $error("phase did not wrap after 256 ticks");
  pwm_hold_a: assert property (!tick && !syncHit |=> $stable(phase))
    else $error("phase moved without a divider tick");
  pwm_sync_a: assert property (syncHit |=> phase == '0 && divCount == '0)
    else $error("horizontal gate did not restart the period");
  pwm_level_a: assert property ($stable(width) && $stable(invert) && phase < width
    |=> pwmOut == !$past(invert))
    else $error("output level wrong for phase below width");
  pwm_idle_a: assert property (phase >= width |=> pwmOut == $past(invert))
    else $error("output active while phase at or above width");
  pwm_wrap_c: cover property (tick && phase == '1);
  pwm_sync_c: cover property (syncHit && phase != '0);
endmodule : brightness_pwm

// >>> design/panel_pad_ctrl.sv
// Panel output pad control: drive codes, delay codes, pin direction, straps and brightness over AXI4-Lite.
// Notes on behaviour
// - Every data group and control output has a 3-bit drive code giving eight steps from weakest to strongest.
// - The panel clock has its own 3-bit drive code whose steps are twice the data output current.
// - Code zero is the weakest step and code seven the strongest, rising monotonically.
// - Each data group, each polarity flag, each sync output, the modulator, the enable pin and the clock have a code.
// - After reset every drive code reads zero, the weakest step.
// - Nineteen of the 21 coded outputs, the modulator not among them, have a 5-bit delay code in fixed steps.
// - Each delayed output has its own delay field, the panel clock one living in output_control_one.
// - The modulator runs from the system clock through a programmable pre-divider.
// - One modulator period is 256 pre-divided ticks.
// - Software programs both the pulse width and the pre-divider value.
// - With sync selected, a rising horizontal gate restarts the modulator period.
// - A configuration bit inverts the modulator output polarity.
// - Reset turns every bidirectional pin, the first three data groups among them, to input.
// - The two strap-shared sync outputs stay input in reset, latch the strap levels, then drive.
//
// Design decisions made here: the register offsets and register access over AXI4-Lite.
module panel_pad_ctrl
  import panel_pad_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W/8-1:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  // Pad controls
  output logic [NUM_DRIVE-1:0][DRIVE_W-1:0] driveCode,
  output logic [NUM_DELAY-1:0][DELAY_W-1:0] padDelay,
  // Bidirectional data groups a to c, enable low while driving
  output logic [NUM_BIDIR-1:0] dataGroupOe_n,
  // Strap-shared sync outputs 2 and 4
  input wire logic [NUM_STRAP-1:0] addressStrap,
  output logic [NUM_STRAP-1:0] syncStrapOe_n,
  output logic [NUM_STRAP-1:0] strapLevel,
  // Brightness modulator
  input wire logic hGate,
  output logic pwmOut
);
  wr_state_t wrState;
  logic [ADDR_W-1:0] wrAddr;
  logic [DATA_W-1:0] wrData;
  logic [DATA_W/8-1:0] wrStrb;
  logic wrFire;
  logic [DATA_W-1:0] merged;
  logic awFire;
  logic wFire;
  logic arFire;
  logic [PHASE_W-1:0] pulseWidth;
  logic syncEnable;
  logic invertOut;
  logic [PREDIV_W-1:0] prediv;
  logic [NUM_BIDIR-1:0] pinDir;
  logic strapDone;
  logic [PHASE_W-1:0] phase;

  function automatic logic [ADDR_W-1:0] delayAddr(input int i);
    delayAddr = OFF_DELAY_BASE + ADDR_W'(i * 4);
  endfunction : delayAddr

  function automatic logic [ADDR_W-1:0] driveAddr(input int r);
    driveAddr = OFF_DRIVE_BASE + ADDR_W'(r * 4);
  endfunction : driveAddr

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < NUM_DELAY; i++) begin
      hit = hit | (a == delayAddr(i));
    end
    for (int r = 0; r < NUM_DRIVE_REG; r++) begin
      hit = hit | (a == driveAddr(r));
    end
    hit = hit | (a == OFF_BRIGHT0) | (a == OFF_BRIGHT1) | (a == OFF_PIN_DIR) | (a == OFF_STATUS);
    isMapped = hit;
  endfunction : isMapped

  // Read view of every register; unused bits read as zero.
  function automatic logic [DATA_W-1:0] readReg(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] v;
    v = '0;
    for (int i = 0; i < NUM_DELAY; i++) begin
      if (a == delayAddr(i)) begin
        v[DELAY_W-1:0] = padDelay[i];
      end
    end
    for (int k = 0; k < NUM_DRIVE; k++) begin
      if (a == driveAddr(k / CODES_PER_REG)) begin
        v[(k % CODES_PER_REG) * DRIVE_W +: DRIVE_W] = driveCode[k];
      end
    end
    if (a == OFF_BRIGHT0) begin
      v[BR_WIDTH_LSB +: PHASE_W] = pulseWidth;
      v[BR_SYNC_BIT] = syncEnable;
      v[BR_INV_BIT] = invertOut;
    end
    if (a == OFF_BRIGHT1) begin
      v[PREDIV_W-1:0] = prediv;
    end
    if (a == OFF_PIN_DIR) begin
      v[NUM_BIDIR-1:0] = pinDir;
    end
    if (a == OFF_STATUS) begin
      v[ST_STRAP_LSB +: NUM_STRAP] = strapLevel;
      v[ST_OUT_BIT] = pwmOut;
      v[ST_PHASE_LSB +: PHASE_W] = phase;
    end
    readReg = v;
  endfunction : readReg

  assign awFire = awvalid && awready;
  assign wFire = wvalid && wready;
  assign arFire = arvalid && arready;
  // The write lands once both address and data are held and no response is pending.
  assign wrFire = (wrState == WR_COLLECT) && !awready && !wready;

  always_comb begin
    merged = readReg(wrAddr);
    for (int b = 0; b < DATA_W / 8; b++) begin
      if (wrStrb[b]) begin
        merged[b*8 +: 8] = wrData[b*8 +: 8];
      end
    end
  end

  // Address and data are taken in either order and held until the write lands.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awready <= 1'b1;
      wrAddr <= '0;
    end else if (awFire) begin
      awready <= 1'b0;
      wrAddr <= awaddr;
    end else if (bvalid && bready) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wready <= 1'b1;
      wrData <= '0;
      wrStrb <= '0;
    end else if (wFire) begin
      wready <= 1'b0;
      wrData <= wdata;
      wrStrb <= wstrb;
    end else if (bvalid && bready) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wrState <= WR_COLLECT;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      case (wrState)
        WR_COLLECT: begin
          if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= isMapped(wrAddr) ? RESP_OKAY : RESP_SLVERR;
            wrState <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (bready) begin
            bvalid <= 1'b0;
            wrState <= WR_COLLECT;
          end
        end
        default: begin
          bvalid <= 1'b0;
          wrState <= WR_COLLECT;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arFire) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= readReg(araddr);
      rresp <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

  // Codes drive the pads directly; a change takes effect one edge after the write.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int k = 0; k < NUM_DRIVE; k++) begin
        driveCode[k] <= DRIVE_RESET;
      end
    end else if (wrFire) begin
      for (int k = 0; k < NUM_DRIVE; k++) begin
        if (wrAddr == driveAddr(k / CODES_PER_REG)) begin
          driveCode[k] <= merged[(k % CODES_PER_REG) * DRIVE_W +: DRIVE_W];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_DELAY; i++) begin
        padDelay[i] <= DELAY_RESET;
      end
    end else if (wrFire) begin
      for (int i = 0; i < NUM_DELAY; i++) begin
        if (wrAddr == delayAddr(i)) begin
          padDelay[i] <= merged[DELAY_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulseWidth <= WIDTH_RESET;
      syncEnable <= 1'b0;
      invertOut <= 1'b0;
      prediv <= PREDIV_RESET;
    end else if (wrFire && wrAddr == OFF_BRIGHT0) begin
      pulseWidth <= merged[BR_WIDTH_LSB +: PHASE_W];
      syncEnable <= merged[BR_SYNC_BIT];
      invertOut <= merged[BR_INV_BIT];
    end else if (wrFire && wrAddr == OFF_BRIGHT1) begin
      prediv <= merged[PREDIV_W-1:0];
    end
  end

  // Software alone turns the bidirectional groups into outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pinDir <= '0;
      dataGroupOe_n <= '1;
    end else begin
      if (wrFire && wrAddr == OFF_PIN_DIR) begin
        pinDir <= merged[NUM_BIDIR-1:0];
      end
      dataGroupOe_n <= ~pinDir;
    end
  end

  // The strap is caught at the first edge after release, while the pads are still inputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strapDone <= 1'b0;
      strapLevel <= '0;
      syncStrapOe_n <= '1;
    end else begin
      syncStrapOe_n <= '0;
      if (!strapDone) begin
        strapDone <= 1'b1;
        strapLevel <= addressStrap;
      end
    end
  end

  brightness_pwm #(
    .DIV_W(PREDIV_W),
    .CNT_W(PHASE_W)
  ) pwmUnit (
    .clk(clk),
    .rst_n(rst_n),
    .prediv(prediv),
    .width(pulseWidth),
    .syncEnable(syncEnable),
    .invert(invertOut),
    .hGate(hGate),
    .pwmOut(pwmOut),
    .phase(phase)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  drive_reset_a: assert property ($rose(rst_n) |-> driveCode == '0)
    else $error("drive codes not weakest after reset");
  bidir_reset_a: assert property ($rose(rst_n) |-> dataGroupOe_n == '1 ##1 dataGroupOe_n == '1)
    else $error("bidirectional group driving right after reset");
  strap_switch_a: assert property ($rose(rst_n) |-> syncStrapOe_n == '1 ##1 syncStrapOe_n == '0)
    else $error("strap pins did not switch to output after reset");
  strap_latch_a: assert property ($rose(rst_n) |=> strapLevel == $past(addressStrap))
    else $error("strap level not latched at release");
  drive_write_a: assert property (wrFire && wrAddr == OFF_DRIVE_BASE && wrStrb == '1
    |=> driveCode[CODES_PER_REG-1:0] == $past(wrData[CODES_PER_REG*DRIVE_W-1:0]))
    else $error("drive codes not taken from write");
  clock_delay_a: assert property (wrFire && wrAddr == delayAddr(DLY_PCLK) && wrStrb[0]
    |=> padDelay[DLY_PCLK] == $past(wrData[DELAY_W-1:0]))
    else $error("clock delay not taken from write");
  dir_apply_a: assert property (wrFire && wrAddr == OFF_PIN_DIR && wrStrb[0]
    |=> ##1 dataGroupOe_n == ~$past(wrData[NUM_BIDIR-1:0], 2))
    else $error("pin direction not applied two edges after write");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped before taken");
  write_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("new write accepted while a response is pending");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("new read accepted while read data is pending");
  strap_hold_a: assert property (strapDone |=> $stable(strapLevel))
    else $error("strap level changed after it was latched");
  drive_keep_a: assert property (!wrFire |=> $stable(driveCode))
    else $error("drive codes changed without a write");
  delay_keep_a: assert property (!wrFire |=> $stable(padDelay))
    else $error("delay codes changed without a write");
  bright_write_a: assert property (wrFire && wrAddr == OFF_BRIGHT0 && wrStrb[1:0] == 2'h3
    |=> pulseWidth == $past(wrData[BR_WIDTH_LSB +: PHASE_W]) && invertOut == $past(wrData[BR_INV_BIT]))
    else $error("brightness settings not taken from write");
  write_ok_c: cover property (wrFire && isMapped(wrAddr));
  read_err_c: cover property (arFire && !isMapped(araddr));
  pin_enable_c: cover property (dataGroupOe_n == '0);
endmodule : panel_pad_ctrl

// >>> bench/panel_side_model.sv
// Panel-side model: strap resistors on the shared sync pins and a horizontal gate source.
module panel_side_model (
  // Clock
  input wire logic clk,
  // Pin direction from the device
  input wire logic [1:0] syncStrapOe_n,
  // Bench settings
  input wire logic [1:0] strapSetting,
  input wire logic [7:0] gatePeriod,
  // Toward the device
  output logic [1:0] addressStrap,
  output logic hGate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] gateCount = 8'h00;
  // Once the device drives the pin the strap is gone; the opposite level exposes a late latch.
  assign addressStrap = ~(strapSetting ^ syncStrapOe_n);
  assign hGate = (gatePeriod != 8'h00) && (gateCount < 8'h0A);
  always @(posedge clk) begin
    if (gatePeriod == 8'h00 || gateCount == gatePeriod - 8'h01) begin
      gateCount <= 8'h00;
    end else begin
      gateCount <= gateCount + 8'h01;
    end
  end
endmodule : panel_side_model

// >>> bench/testbench.sv
// Self-checking bench for the panel output pad control block.
module testbench
  import panel_pad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, gatePeriod = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] strapSetting = 2'h2;
  logic awready, wready, bvalid, arready, rvalid, hGate, pwmOut;
  logic [1:0] bresp, rresp, addressStrap, syncStrapOe_n, strapLevel;
  logic [31:0] rdata;
  logic [NUM_DRIVE-1:0][DRIVE_W-1:0] driveCode;
  logic [NUM_DELAY-1:0][DELAY_W-1:0] padDelay;
  logic [NUM_BIDIR-1:0] dataGroupOe_n;
  int numErrors = 0, compares = 0, cycles = 0;

  always #5 clk = ~clk;

  panel_pad_ctrl dut (.clk, .rst_n, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb,
    .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .driveCode, .padDelay, .dataGroupOe_n, .addressStrap, .syncStrapOe_n, .strapLevel, .hGate, .pwmOut);

  panel_side_model farSide (.clk, .syncStrapOe_n, .strapSetting, .gatePeriod, .addressStrap, .hGate);

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, numErrors);
    if (numErrors == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // The scenarios should need about 6000 cycles; the ceiling leaves ample margin.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      numErrors++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r,
    input int lag = 0);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(ad && dd));
    repeat (lag) @(posedge clk);
    bready <= 1'b1;
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r, input int lag = 0);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    repeat (lag) @(posedge clk);
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  task automatic count_high(input int settle, input int len, output int n);
    repeat (settle) @(posedge clk);
    n = 0;
    repeat (len) begin
      @(posedge clk);
      if (pwmOut === 1'b1) n++;
    end
  endtask : count_high

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    check("drive", 32'h0, 32'(|driveCode));
    check("delay", 32'h0, 32'(|padDelay));
    check("groupOe", 32'h7, 32'(dataGroupOe_n));
    check("strapOe", 32'h3, 32'(syncStrapOe_n));
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("strapOe", 32'h0, 32'(syncStrapOe_n));
    check("strapLevel", 32'h2, 32'(strapLevel));
    axr(OFF_STATUS, d, r);
    check("statusStrap", 32'h2, 32'(d[1:0]));
  endtask : t_reset

  task automatic t_delay;
    logic [31:0] d;
    logic [1:0] r;
    for (int k = 0; k < NUM_DELAY; k++) begin
      axw(8'(4 * k), 32'(31 - k), 4'hF, r);
      check("delayResp", 32'(RESP_OKAY), 32'(r));
      check("padDelay", 32'(31 - k), 32'(padDelay[k]));
      axr(8'(4 * k), d, r);
      check("delayRead", 32'(31 - k), d);
    end
    for (int k = 0; k < NUM_DELAY; k++) check("padDelay", 32'(31 - k), 32'(padDelay[k]));
  endtask : t_delay

  task automatic t_drive;
    logic [31:0] d, q;
    logic [1:0] r;
    for (int g = 0; g < NUM_DRIVE_REG; g++) begin
      d = 32'h0;
      for (int j = 0; j < CODES_PER_REG && g * 8 + j < NUM_DRIVE; j++) d[3 * j +: 3] = 3'(7 - j);
      axw(8'(OFF_DRIVE_BASE + 8'(4 * g)), d, 4'hF, r);
      axr(8'(OFF_DRIVE_BASE + 8'(4 * g)), q, r);
      check("driveRead", d, q);
    end
    for (int s = 0; s < NUM_DRIVE; s++) check("driveCode", 32'(7 - s % 8), 32'(driveCode[s]));
    // Lane 0 only: slots 0 and 1 clear, slot 2 keeps its top bit.
    axw(OFF_DRIVE_BASE, 32'h0, 4'h1, r);
    check("driveCode", 32'h0, 32'(driveCode[0]));
    check("driveCode", 32'h4, 32'(driveCode[2]));
  endtask : t_drive

  task automatic t_pins;
    logic [31:0] d;
    logic [1:0] r;
    axw(OFF_PIN_DIR, 32'h5, 4'hF, r);
    @(posedge clk);
    check("groupOe", 32'h2, 32'(dataGroupOe_n));
    axw(OFF_PIN_DIR, 32'h7, 4'h1, r);
    @(posedge clk);
    check("groupOe", 32'h0, 32'(dataGroupOe_n));
    axw(8'h70, 32'h1, 4'hF, r);
    check("unmappedResp", 32'(RESP_SLVERR), 32'(r));
    axw(8'h02, 32'h1, 4'hF, r);
    check("misalignResp", 32'(RESP_SLVERR), 32'(r));
    check("padDelay", 32'h1F, 32'(padDelay[0]));
    axr(8'h70, d, r);
    check("unmappedData", 32'h0, d);
    check("unmappedRd", 32'(RESP_SLVERR), 32'(r));
    axw(OFF_STATUS, 32'h0, 4'hF, r, 3);
    check("statusResp", 32'(RESP_OKAY), 32'(r));
    axr(OFF_STATUS, d, r, 2);
    check("statusStrap", 32'h2, 32'(d[1:0]));
  endtask : t_pins

  task automatic t_pwm;
    logic [1:0] r;
    int n;
    logic [9:0] cfg [4] = '{10'h040, 10'h240, 10'h000, 10'h0FF};
    int want [4] = '{128, 384, 0, 510};
    axw(OFF_BRIGHT1, 32'h1, 4'hF, r);
    for (int i = 0; i < 4; i++) begin
      axw(OFF_BRIGHT0, 32'(cfg[i]), 4'hF, r);
      count_high(600, 512, n);
      check("pwmHigh", 32'(want[i]), 32'(n));
    end
  endtask : t_pwm

  task automatic t_sync;
    logic [1:0] r;
    int n;
    axw(OFF_BRIGHT1, 32'h0, 4'hF, r);
    gatePeriod <= 8'h64;
    axw(OFF_BRIGHT0, 32'h132, 4'hF, r);
    count_high(300, 300, n);
    check("pwmSync", 32'h96, 32'(n));
    axw(OFF_BRIGHT0, 32'h32, 4'hF, r);
    count_high(300, 256, n);
    check("pwmFree", 32'h32, 32'(n));
  endtask : t_sync

  task automatic t_rerun;
    rst_n <= 1'b0;
    strapSetting <= 2'h1;
    repeat (3) @(posedge clk);
    check("drive", 32'h0, 32'(|driveCode));
    check("groupOe", 32'h7, 32'(dataGroupOe_n));
    check("strapOe", 32'h3, 32'(syncStrapOe_n));
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check("strapOe", 32'h0, 32'(syncStrapOe_n));
    check("strapLevel", 32'h1, 32'(strapLevel));
  endtask : t_rerun

  initial begin
    repeat (10) @(posedge clk);
    t_reset();
    t_delay();
    t_drive();
    t_pins();
    t_pwm();
    t_sync();
    t_rerun();
    wrap_up();
  end
endmodule : testbench
